// ==== logic/rcc_core.sv ====
// Real-time clock and calendar core with an APB register slave.
`timescale 1ns/1ps
`default_nettype none
module rcc_core #(
  parameter int TB_PULSES = rcc_pkg::TB_PULSES_PER_SEC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rcc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timebase_in,
  input wire logic sys_rst_req,
  output logic rtc_pin
);
  // ************************************************************
  // BCD helpers
  // ************************************************************
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = (v[3:0] == 4'h9) ? {4'(v[7:4] + 4'h1), 4'h0} : 8'(v + 8'h01);
    return r;
  endfunction

  function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    logic [7:0] r;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      8'h02: r = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
      default: r = 8'h31;
    endcase
    return r;
  endfunction

  // ************************************************************
  // APB decode
  // ************************************************************
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic en_q;
  logic unlock_q;
  logic oe_q;
  logic [1:0] vptr_q;
  logic [7:0] cal_q;
  logic [1:0] osel_q;
  logic [7:0] acfg_q;
  logic [7:0] sec_q, min_q, hour_q, wday_q, day_q, mon_q, year_q;
  logic [7:0] sec_d, min_d, hour_d, wday_d, day_d, mon_d, year_d;
  logic [7:0] asec_q, amin_q, ahour_q, awday_q, aday_q, amon_q;
  logic tb_q;
  logic tick_q1;
  logic alarm_q;
  logic pin_q;
  logic sec_tick;
  logic half_sec;
  logic ripple;

  wire logic setup = psel & ~penable;
  wire logic done = psel & penable & pready_q;
  wire logic wr = done & pwrite;
  wire logic aligned = (paddr[1:0] == 2'b00);
  wire logic [11:0] idx = paddr[rcc_pkg::ADDR_W-1:2];
  wire logic hit_osel = aligned & (idx == rcc_pkg::IDX_OUT_SEL);
  wire logic hit_cal = aligned & (idx == rcc_pkg::IDX_CAL);
  wire logic hit_cfg = aligned & (idx == rcc_pkg::IDX_CFG);
  wire logic hit_vlow = aligned & (idx == rcc_pkg::IDX_VAL_LOW);
  wire logic hit_vhigh = aligned & (idx == rcc_pkg::IDX_VAL_HIGH);
  wire logic hit_alow = aligned & (idx == rcc_pkg::IDX_ALM_LOW);
  wire logic hit_ahigh = aligned & (idx == rcc_pkg::IDX_ALM_HIGH);
  wire logic hit_acfg = aligned & (idx == rcc_pkg::IDX_ALM_CFG);
  wire logic mapped = hit_osel | hit_cal | hit_cfg | hit_vlow | hit_vhigh
                    | hit_alow | hit_ahigh | hit_acfg;

  wire logic [1:0] aptr = acfg_q[1:0];
  wire logic vlow_wr = wr & hit_vlow & unlock_q;
  wire logic vhigh_wr = wr & hit_vhigh & unlock_q;
  wire logic vhigh_acc = done & hit_vhigh;
  wire logic alow_wr = wr & hit_alow;
  wire logic ahigh_wr = wr & hit_ahigh;
  wire logic ahigh_acc = done & hit_ahigh;
  wire logic [7:0] wb = pwdata[7:0];
  wire logic sec_wr = vlow_wr & (vptr_q == rcc_pkg::PTR_0);

  // ************************************************************
  // Read selection
  // ************************************************************
  // value window mapping
  wire logic [7:0] vhigh_rd = (vptr_q == rcc_pkg::PTR_0) ? min_q :
                              (vptr_q == rcc_pkg::PTR_1) ? wday_q :
                              (vptr_q == rcc_pkg::PTR_2) ? mon_q : 8'h00;
  wire logic [7:0] vlow_rd = (vptr_q == rcc_pkg::PTR_0) ? sec_q :
                             (vptr_q == rcc_pkg::PTR_1) ? hour_q :
                             (vptr_q == rcc_pkg::PTR_2) ? day_q : year_q;
  wire logic [7:0] ahigh_rd = (aptr == rcc_pkg::PTR_0) ? amin_q :
                              (aptr == rcc_pkg::PTR_1) ? awday_q :
                              (aptr == rcc_pkg::PTR_2) ? amon_q : 8'h00;
  wire logic [7:0] alow_rd = (aptr == rcc_pkg::PTR_0) ? asec_q :
                             (aptr == rcc_pkg::PTR_1) ? ahour_q :
                             (aptr == rcc_pkg::PTR_2) ? aday_q : 8'h00;
  wire logic [7:0] cfg_rd = {en_q, 1'b0, unlock_q, ripple, half_sec, oe_q, vptr_q};
  wire logic [7:0] osel_rd = {5'h00, osel_q, 1'b0};
  wire logic [7:0] rd_byte = hit_cfg ? cfg_rd :
                             hit_cal ? cal_q :
                             hit_osel ? osel_rd :
                             hit_vlow ? vlow_rd :
                             hit_vhigh ? vhigh_rd :
                             hit_alow ? alow_rd :
                             hit_ahigh ? ahigh_rd :
                             hit_acfg ? acfg_q : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) begin
        prdata_q <= {24'h000000, rd_byte};
      end
    end
  end

  // ************************************************************
  // Configuration register
  // ************************************************************
  // Only the power-on reset touches this register; a system reset
  // request leaves enable, unlock, output enable and pointer alone.
  // power-on only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      unlock_q <= 1'b0;
      oe_q <= 1'b0;
      vptr_q <= rcc_pkg::PTR_0;
    end else if (wr && hit_cfg) begin
      if (unlock_q) begin
        en_q <= wb[rcc_pkg::CFG_EN_BIT];
      end
      unlock_q <= wb[rcc_pkg::CFG_UNLOCK_BIT];
      oe_q <= wb[rcc_pkg::CFG_OE_BIT];
      vptr_q <= wb[1:0];
    end else if (vhigh_acc && vptr_q != rcc_pkg::PTR_0) begin
      vptr_q <= 2'(vptr_q - 2'h1);
    end
  end

  // ************************************************************
  // Control registers cleared by any reset
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_q <= 8'h00;
      osel_q <= rcc_pkg::OUT_ALARM;
      acfg_q <= 8'h00;
    end else if (sys_rst_req) begin
      cal_q <= 8'h00;
      osel_q <= rcc_pkg::OUT_ALARM;
      acfg_q <= 8'h00;
    end else begin
      if (wr && hit_cal) begin
        cal_q <= wb;
      end
      if (wr && hit_osel) begin
        osel_q <= wb[rcc_pkg::OUT_SEL_LSB +: 2];
      end
      if (wr && hit_acfg) begin
        acfg_q <= wb;
      end else if (ahigh_acc && aptr != rcc_pkg::PTR_0) begin
        acfg_q[1:0] <= 2'(aptr - 2'h1);
      end
    end
  end

  // ************************************************************
  // Timebase and prescaler
  // ************************************************************
  // timebase edge pulse
  wire logic tb_pulse = timebase_in & ~tb_q;

  // ************************************************************
  // Calendar cascade
  // ************************************************************
  wire logic c_min = sec_tick & (sec_q == rcc_pkg::MAX_SEC);
  wire logic c_hour = c_min & (min_q == rcc_pkg::MAX_SEC);
  wire logic c_day = c_hour & (hour_q == rcc_pkg::MAX_HOUR);
  wire logic c_mon = c_day & (day_q == last_day(mon_q, year_q));
  wire logic c_year = c_mon & (mon_q == rcc_pkg::MAX_MON);

  rcc_prescaler #(
    .TB_PULSES(TB_PULSES)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .clear(sys_rst_req | sec_wr),
    .run(en_q),
    .tb_pulse(tb_pulse),
    .cal_arm(c_min),
    .cal(cal_q),
    .sec_tick(sec_tick),
    .half_sec(half_sec),
    .ripple(ripple)
  );

  // A software write to a field wins over the tick in the same cycle,
  // so a freshly written value is never bumped before it is seen.
  always_comb begin
    sec_d = !sec_tick ? sec_q : c_min ? 8'h00 : bcd_inc(sec_q);
    min_d = !c_min ? min_q : c_hour ? 8'h00 : bcd_inc(min_q);
    hour_d = !c_hour ? hour_q : c_day ? 8'h00 : bcd_inc(hour_q);
    wday_d = !c_day ? wday_q : (wday_q == rcc_pkg::MAX_WDAY) ? 8'h00 : 8'(wday_q + 8'h01);
    day_d = !c_day ? day_q : c_mon ? rcc_pkg::RST_DAY : bcd_inc(day_q);
    mon_d = !c_mon ? mon_q : c_year ? rcc_pkg::RST_MON : bcd_inc(mon_q);
    year_d = !c_year ? year_q : (year_q == rcc_pkg::MAX_YEAR) ? 8'h00 : bcd_inc(year_q);
    if (vlow_wr) begin
      case (vptr_q)
        rcc_pkg::PTR_0: sec_d = wb & rcc_pkg::MASK_SEC;
        rcc_pkg::PTR_1: hour_d = wb & rcc_pkg::MASK_HOUR;
        rcc_pkg::PTR_2: day_d = wb & rcc_pkg::MASK_HOUR;
        default: year_d = wb;
      endcase
    end
    if (vhigh_wr) begin
      case (vptr_q)
        rcc_pkg::PTR_0: min_d = wb & rcc_pkg::MASK_SEC;
        rcc_pkg::PTR_1: wday_d = wb & rcc_pkg::MASK_WDAY;
        rcc_pkg::PTR_2: mon_d = wb & rcc_pkg::MASK_MON;
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_q <= rcc_pkg::RST_SEC;
      min_q <= rcc_pkg::RST_MIN;
      hour_q <= rcc_pkg::RST_HOUR;
      wday_q <= rcc_pkg::RST_WDAY;
      day_q <= rcc_pkg::RST_DAY;
      mon_q <= rcc_pkg::RST_MON;
      year_q <= rcc_pkg::RST_YEAR;
    end else begin
      sec_q <= sec_d;
      min_q <= min_d;
      hour_q <= hour_d;
      wday_q <= wday_d;
      day_q <= day_d;
      mon_q <= mon_d;
      year_q <= year_d;
    end
  end

  // ************************************************************
  // Alarm values and alarm pulse
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      asec_q <= 8'h00;
      amin_q <= 8'h00;
      ahour_q <= 8'h00;
      awday_q <= 8'h00;
      aday_q <= 8'h00;
      amon_q <= 8'h00;
    end else begin
      if (alow_wr && aptr == rcc_pkg::PTR_0) begin
        asec_q <= wb & rcc_pkg::MASK_SEC;
      end
      if (alow_wr && aptr == rcc_pkg::PTR_1) begin
        ahour_q <= wb & rcc_pkg::MASK_HOUR;
      end
      if (alow_wr && aptr == rcc_pkg::PTR_2) begin
        aday_q <= wb & rcc_pkg::MASK_HOUR;
      end
      if (ahigh_wr && aptr == rcc_pkg::PTR_0) begin
        amin_q <= wb & rcc_pkg::MASK_SEC;
      end
      if (ahigh_wr && aptr == rcc_pkg::PTR_1) begin
        awday_q <= wb & rcc_pkg::MASK_WDAY;
      end
      if (ahigh_wr && aptr == rcc_pkg::PTR_2) begin
        amon_q <= wb & rcc_pkg::MASK_MON;
      end
    end
  end

  // The match is tested one cycle after the tick, once the new time
  // has settled; the pulse then lasts until the next second tick.
  wire logic alarm_match = (sec_q == asec_q) & (min_q == amin_q) & (hour_q == ahour_q)
                         & (wday_q == awday_q) & (day_q == aday_q) & (mon_q == amon_q);

  // ************************************************************
  // Output pin
  // ************************************************************
  // output source select
  wire logic pin_src = (osel_q == rcc_pkg::OUT_ALARM) ? alarm_q :
                       (osel_q == rcc_pkg::OUT_SECONDS) ? ~half_sec :
                       (osel_q == rcc_pkg::OUT_TIMEBASE) ? tb_q : 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_q <= 1'b0;
      tick_q1 <= 1'b0;
      alarm_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      tb_q <= timebase_in;
      tick_q1 <= sec_tick;
      if (sys_rst_req) begin
        alarm_q <= 1'b0;
      end else if (tick_q1 && acfg_q[rcc_pkg::ALM_EN_BIT] && alarm_match) begin
        alarm_q <= 1'b1;
      end else if (sec_tick) begin
        alarm_q <= 1'b0;
      end
      pin_q <= oe_q & pin_src;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rtc_pin = pin_q;
endmodule // rcc_core
`default_nettype wire

// ==== logic/rcc_pkg.sv ====
// Constants shared by the real-time clock and calendar core.
`default_nettype none
package rcc_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  // Registers are indexed; the byte address is four times the index.
  localparam int ADDR_W = 14;
  localparam logic [11:0] IDX_OUT_SEL = 12'hF3C;
  localparam logic [11:0] IDX_CAL = 12'hF3E;
  localparam logic [11:0] IDX_CFG = 12'hF3F;
  localparam logic [11:0] IDX_VAL_LOW = 12'hF40;
  localparam logic [11:0] IDX_VAL_HIGH = 12'hF41;
  localparam logic [11:0] IDX_ALM_LOW = 12'hF44;
  localparam logic [11:0] IDX_ALM_HIGH = 12'hF45;
  localparam logic [11:0] IDX_ALM_CFG = 12'hF47;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CFG_EN_BIT = 7;
  localparam int CFG_UNLOCK_BIT = 5;
  localparam int CFG_SYNC_BIT = 4;
  localparam int CFG_HALF_BIT = 3;
  localparam int CFG_OE_BIT = 2;
  localparam int OUT_SEL_LSB = 1;
  localparam int ALM_EN_BIT = 7;

  // ************************************************************
  // Codes
  // ************************************************************
  localparam logic [1:0] PTR_0 = 2'h0;
  localparam logic [1:0] PTR_1 = 2'h1;
  localparam logic [1:0] PTR_2 = 2'h2;
  localparam logic [1:0] OUT_ALARM = 2'h0;
  localparam logic [1:0] OUT_SECONDS = 2'h1;
  localparam logic [1:0] OUT_TIMEBASE = 2'h2;

  // ************************************************************
  // Timing, in timebase pulses; calibration shift and prescaler width in bits
  // ************************************************************
  localparam int TB_PULSES_PER_SEC = 32768;
  localparam int CAL_SHIFT = 2;
  localparam int SYNC_WINDOW = 32;
  localparam int PRE_W = 17;

  // ************************************************************
  // Reset values, field masks and digit limits (BCD)
  // ************************************************************
  localparam logic [7:0] RST_SEC = 8'h00;
  localparam logic [7:0] RST_MIN = 8'h00;
  localparam logic [7:0] RST_HOUR = 8'h00;
  localparam logic [7:0] RST_WDAY = 8'h06;
  localparam logic [7:0] RST_DAY = 8'h01;
  localparam logic [7:0] RST_MON = 8'h01;
  localparam logic [7:0] RST_YEAR = 8'h00;
  localparam logic [7:0] MASK_SEC = 8'h7F;
  localparam logic [7:0] MASK_HOUR = 8'h3F;
  localparam logic [7:0] MASK_WDAY = 8'h07;
  localparam logic [7:0] MASK_MON = 8'h1F;
  localparam logic [7:0] MAX_SEC = 8'h59;
  localparam logic [7:0] MAX_HOUR = 8'h23;
  localparam logic [7:0] MAX_WDAY = 8'h06;
  localparam logic [7:0] MAX_MON = 8'h12;
  localparam logic [7:0] MAX_YEAR = 8'h99;
endpackage
`default_nettype wire

// ==== logic/rcc_prescaler.sv ====
// Timebase prescaler with per-minute drift correction.
`timescale 1ns/1ps
`default_nettype none
module rcc_prescaler #(
  parameter int TB_PULSES = rcc_pkg::TB_PULSES_PER_SEC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic run,
  input wire logic tb_pulse,
  input wire logic cal_arm,
  input wire logic [7:0] cal,
  output logic sec_tick,
  output logic half_sec,
  output logic ripple
);
  localparam int W = rcc_pkg::PRE_W;
  localparam logic signed [W-1:0] BASE = W'(TB_PULSES);
  localparam logic [W-1:0] HALF = W'(TB_PULSES / 2);
  localparam logic signed [W-1:0] WIN = W'(rcc_pkg::SYNC_WINDOW);

  logic [W-1:0] cnt_q;
  logic use_cal_q;
  logic sec_tick_q;
  logic half_q;
  logic ripple_q;

  wire logic signed [W-1:0] cal_adj = {{(W - 10){cal[7]}}, cal, 2'b00};
  wire logic signed [W-1:0] term = use_cal_q ? BASE - cal_adj : BASE;
  wire logic at_end = (cnt_q == W'(term - 1));
  wire logic step = tb_pulse & run;
  wire logic [W-1:0] cnt_d = clear ? '0 : !step ? cnt_q : at_end ? '0 : W'(cnt_q + 1'b1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      use_cal_q <= 1'b0;
      sec_tick_q <= 1'b0;
      half_q <= 1'b0;
      ripple_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sec_tick_q <= step & at_end & ~clear;
      if (clear || (step && at_end)) begin
        use_cal_q <= cal_arm;
      end else if (cal_arm) begin
        use_cal_q <= 1'b1;
      end
      half_q <= (cnt_d >= HALF);
      ripple_q <= run & ($signed(cnt_d) >= term - WIN);
    end
  end

  assign sec_tick = sec_tick_q;
  assign half_sec = half_q;
  assign ripple = ripple_q;
endmodule // rcc_prescaler
`default_nettype wire

// ==== sim/rcc_core_checker.sv ====
// Checker for the clock core's register bus and output pin.
`timescale 1ns/1ps
`default_nettype none
module rcc_core_checker #(
  parameter int TB_PULSES = 32768
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rcc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timebase_in,
  input wire logic sys_rst_req,
  input wire logic rtc_pin
);
  localparam logic [13:0] A_CFG = {rcc_pkg::IDX_CFG, 2'h0};
  localparam logic [13:0] A_SEL = {rcc_pkg::IDX_OUT_SEL, 2'h0};
  logic setup;
  logic wr_ok;
  logic oe_q;
  logic [1:0] sel_q;
  assign setup = psel && !penable;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  // The enable mirror follows bus writes only; the select mirror also clears on a system reset request; the enable bit of the output is never write-locked.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_q <= 1'b0;
      sel_q <= 2'h0;
    end else begin
      oe_q <= (wr_ok && paddr == A_CFG) ? pwdata[2] : oe_q;
      sel_q <= sys_rst_req ? 2'h0 : (wr_ok && paddr == A_SEL) ? pwdata[2:1] : sel_q;
    end
  end
  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_ready_next: assert property (setup |=> pready ##1 !pready)
    else $error("pready is not a single pulse after setup");
  chk_ready_cause: assert property ($rose(pready) |-> $past(psel) && !$past(penable))
    else $error("pready rose without a setup cycle");
  chk_err_align: assert property (setup && paddr[1:0] != 2'h0
    |=> pslverr && prdata == 32'h0)
    else $error("unaligned access not refused");
  chk_err_gap: assert property (setup && paddr == 14'h3CF4 |=> pslverr)
    else $error("unmapped access not refused");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_rdata_hold: assert property (!setup |=> $stable(prdata))
    else $error("read data changed outside a setup");
  chk_cfg_spare: assert property (setup && !pwrite && paddr == A_CFG
    |=> !prdata[6] && !pslverr)
    else $error("config spare bit or error set");
  chk_sel_read: assert property (setup && !pwrite && paddr == A_SEL
    |=> prdata == {29'h0, sel_q, 1'b0})
    else $error("output select read back wrong");
  chk_pin_off: assert property (!oe_q ##1 !oe_q |-> !rtc_pin)
    else $error("pin driven with output disabled");
  chk_pin_spare: assert property (sel_q == 2'h3 ##1 sel_q == 2'h3 |-> !rtc_pin)
    else $error("pin active on reserved source");
endmodule // rcc_core_checker
bind rcc_core rcc_core_checker #(.TB_PULSES(TB_PULSES)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timebase_in(timebase_in), .sys_rst_req(sys_rst_req), .rtc_pin(rtc_pin)
);
`default_nettype wire

// ==== sim/rtc_calendar_core_tb_top.sv ====
// Self-checking bench for the clock and calendar core.
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar_core_tb_top;
  // ************************************************************
  // Constants and signals
  // ************************************************************
  localparam int TBP = 1024;
  localparam int SEC = 2 * TBP;
  localparam int LIMIT = 50000;
  localparam logic [13:0] A_SEL = {rcc_pkg::IDX_OUT_SEL, 2'h0};
  localparam logic [13:0] A_CAL = {rcc_pkg::IDX_CAL, 2'h0};
  localparam logic [13:0] A_CFG = {rcc_pkg::IDX_CFG, 2'h0};
  localparam logic [13:0] A_VL = {rcc_pkg::IDX_VAL_LOW, 2'h0};
  localparam logic [13:0] A_VH = {rcc_pkg::IDX_VAL_HIGH, 2'h0};
  localparam logic [13:0] A_AL = {rcc_pkg::IDX_ALM_LOW, 2'h0};
  localparam logic [13:0] A_AH = {rcc_pkg::IDX_ALM_HIGH, 2'h0};
  localparam logic [13:0] A_ACF = {rcc_pkg::IDX_ALM_CFG, 2'h0};
  typedef struct {
    logic [7:0] yr, mon, day, wd, eyr, emon, eday, ewd;
  } rcc_row_t;
  // Each row starts at 23:59:59 and expects the following day after one tick.
  rcc_row_t rows [6] = '{
    '{8'h24, 8'h02, 8'h28, 8'h03, 8'h24, 8'h02, 8'h29, 8'h04},
    '{8'h23, 8'h02, 8'h28, 8'h02, 8'h23, 8'h03, 8'h01, 8'h03},
    '{8'h24, 8'h02, 8'h29, 8'h04, 8'h24, 8'h03, 8'h01, 8'h05},
    '{8'h24, 8'h04, 8'h30, 8'h02, 8'h24, 8'h05, 8'h01, 8'h03},
    '{8'h24, 8'h01, 8'h31, 8'h03, 8'h24, 8'h02, 8'h01, 8'h04},
    '{8'h99, 8'h12, 8'h31, 8'h06, 8'h00, 8'h01, 8'h01, 8'h00}
  };
  string nm [8] = '{"year", "spare", "day", "month", "hour", "weekday", "second", "minute"};
  // Alarm day, month, hour, weekday, second and minute, in alarm pointer order.
  logic [7:0] alm [6] = '{8'h01, 8'h01, 8'h00, 8'h06, 8'h02, 8'h03};
  logic pclk, presetn, psel, penable, pwrite, timebase_in, sys_rst_req, pready, pslverr, rtc_pin;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] p;
  int num_errors, samples_checked, cycles;
  rcc_core #(.TB_PULSES(TBP)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timebase_in(timebase_in), .sys_rst_req(sys_rst_req), .rtc_pin(rtc_pin)
  );
  always #10 pclk = ~pclk;
  always @(posedge pclk) timebase_in <= ~timebase_in;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      num_errors++;
      end_of_test();
    end
  end
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkb(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // The request is held until pready is seen high; the global cycle limit ends a hang.
  task automatic apb(input logic wr, input logic [13:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic w(input logic [13:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rchk(input string n, input logic [13:0] a, input logic [7:0] x,
                      input logic [7:0] m);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(n, {24'h000000, x}, r & {24'hFFFFFF, m});
  endtask
  task automatic wr_rd(input string n, input logic [13:0] a, input logic [7:0] d,
                       input logic [7:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chkb(n, xe, e);
    apb(1'b0, a, 8'h00, r, e);
    chkb(n, xe, e);
    chk(n, {24'h000000, x}, r);
  endtask
  task automatic set_time(input rcc_row_t t);
    logic [7:0] v [8];
    v = '{t.yr, 8'h00, t.day, t.mon, 8'h23, t.wd, 8'h59, 8'h59};
    w(A_CFG, 8'h23);
    for (int i = 0; i < 8; i++) begin
      w(i[0] ? A_VH : A_VL, v[i]);
    end
  endtask
  task automatic read_all(input logic [7:0] x [8]);
    w(A_CFG, 8'hA3);
    for (int i = 0; i < 8; i++) begin
      rchk(nm[i], i[0] ? A_VH : A_VL, x[i], 8'hFF);
    end
  endtask
  task automatic cal_case(input logic [7:0] c, input int n);
    w(A_CAL, c);
    w(A_VL, 8'h59);
    waitc(SEC + 2 * n - 45);
    rchk("cal_before", A_VL, 8'h00, 8'hFF);
    waitc(80);
    rchk("cal_after", A_VL, 8'h01, 8'hFF);
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0000;
    pwdata = 32'h00000000;
    timebase_in = 1'b0;
    sys_rst_req = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      set_time(rows[i]);
      w(A_CFG, 8'hA0);
      waitc(SEC + 20);
      read_all('{rows[i].eyr, 8'h00, rows[i].eday, rows[i].emon, 8'h00, rows[i].ewd, 8'h00,
                 8'h00});
      $display("test rollover row %0d done", i);
    end
    presetn <= 1'b0;
    waitc(2);
    presetn <= 1'b1;
    rchk("cfg_por", A_CFG, 8'h00, 8'hFF);
    w(A_VL, 8'h45);
    read_all('{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h06, 8'h00, 8'h00});
    rchk("cfg_lock", A_CFG, 8'h20, 8'hE7);
    $display("test reset and lock done");
    wr_rd("cal_pos", A_CAL, 8'h7F, 8'h7F, 1'b0);
    wr_rd("cal_neg", A_CAL, 8'h80, 8'h80, 1'b0);
    wr_rd("sel_all", A_SEL, 8'hFF, 8'h06, 1'b0);
    wr_rd("alarm_cfg", A_ACF, 8'h7E, 8'h7E, 1'b0);
    wr_rd("gap", 14'h3CF4, 8'h5A, 8'h00, 1'b1);
    wr_rd("unaligned", A_CFG + 14'h2, 8'hA5, 8'h00, 1'b1);
    w(A_AL, 8'h15);
    w(A_AH, 8'h03);
    rchk("alarm_ptr", A_ACF, 8'h7D, 8'hFF);
    w(A_ACF, 8'h7E);
    rchk("alarm_day", A_AL, 8'h15, 8'hFF);
    rchk("alarm_month", A_AH, 8'h03, 8'hFF);
    $display("test registers done");
    w(A_CFG, 8'hA4);
    @(posedge pclk);
    sys_rst_req <= 1'b1;
    @(posedge pclk);
    sys_rst_req <= 1'b0;
    rchk("cfg_keep", A_CFG, 8'hA4, 8'hE7);
    rchk("cal_clear", A_CAL, 8'h00, 8'hFF);
    $display("test local reset done");
    // Let the half flag come up first, so that the seconds write has something to clear.
    waitc(TBP + 64);
    w(A_VL, 8'h10);
    rchk("half_clear", A_CFG, 8'h00, 8'h18);
    for (int s = 0; s < 4; s++) begin
      w(A_SEL, {5'h00, s[1:0], 1'b0});
      waitc(3);
      p[0] = rtc_pin;
      waitc(1);
      p[1] = rtc_pin;
      if (s != 2) chkb("pin_level", s == 1, p[0]);
      chkb("pin_toggle", s == 2, p[0] ^ p[1]);
    end
    w(A_CFG, 8'hA0);
    w(A_SEL, 8'h02);
    waitc(3);
    chkb("pin_off", 1'b0, rtc_pin);
    waitc(TBP);
    rchk("half_set", A_CFG, 8'h08, 8'h18);
    waitc(TBP - 80);
    rchk("ripple", A_CFG, 8'h18, 8'h18);
    waitc(60);
    rchk("sec_step", A_VL, 8'h11, 8'hFF);
    $display("test half second and pin done");
    // Positive steps shorten the corrected second, negative steps lengthen it.
    cal_case(8'h7F, TBP - 508);
    cal_case(8'h80, TBP + 512);
    cal_case(8'h00, TBP);
    $display("test calibration done");
    w(A_ACF, 8'h82);
    foreach (alm[i]) begin
      w(i[0] ? A_AH : A_AL, alm[i]);
    end
    w(A_SEL, 8'h00);
    w(A_CFG, 8'hA4);
    chkb("alarm_idle", 1'b0, rtc_pin);
    waitc(SEC);
    chkb("alarm_pin", 1'b1, rtc_pin);
    $display("test alarm done");
    end_of_test();
  end
endmodule // rtc_calendar_core_tb_top
`default_nettype wire
